/* logic/smbsp_dev.sv */
// Purpose: smbus slave port and register file of the redriver
// Assumes: host drives scl; both lines pass two flip-flops here
// Notes: one register byte per write transfer, one per read transfer
// Summary of operation
// - port serves bus only with strap high
// - all selects low gives address b0
// - address byte is b0 plus twice select
// - upper seven bits address, lsb direction
// - data changes only while clock low
// - data falling with clock high is start
// - data rising with clock high is stop
// - long high on both lines means idle
// - write is address, register, data, stop
// - device acks address, register, data bytes
// - read uses repeated start, device sends byte
// - host nacks read byte; device releases data
// - status bits six to three show selects
// - status bit two shows memory load done
// - power-down register disables lanes per bit
// - loopback field selects loopback path
// - override bit hands power-down to register
// - channel writes need enable bit or crc
// - reset bit restores defaults, self clears
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
module smbsp_dev (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // serial link
  smbsp_link_if.dev link,
  // straps and pins
  input wire logic i_slave_iface_strap,
  input wire logic [3:0] i_addr_select,
  input wire logic i_power_down_pin,
  input wire logic i_loopback_pin,
  input wire logic i_eeprom_done,
  // lane controls
  output logic [7:0] o_per_lane_power_down,
  output logic o_loop_a_to_b,
  output logic o_loop_b_to_a
);
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADDR = 3'h1,
    S_ACK = 3'h3,
    S_REG = 3'h2,
    S_WDATA = 3'h6,
    S_READ = 3'h7,
    S_IGNORE = 3'h5
  } smbsp_dstate_t;

  function automatic logic [7:0] smbsp_crc8(input logic [7:0] d);
    logic [7:0] c;
    c = d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ smbsp_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : smbsp_crc8

  // synchronisers
  logic scl_m_reg, scl_s_reg, scl_p_reg;
  logic sda_m_reg, sda_s_reg, sda_p_reg;
  logic [7:0] pins_m_reg, pins_s_reg;
  // serial engine
  smbsp_dstate_t st_reg, st_next, after_reg, after_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] tx_reg, tx_next;
  logic oe_n_reg, oe_n_next;
  logic wr_fire;
  localparam int IDLE_W = smbsp_pkg::IDLE_W;
  logic [IDLE_W-1:0] idle_cnt_reg;
  logic stop_seen_reg;
  // registers
  logic [7:0] obs_rw_reg, pd_reg, lpo_reg, crc_reg, src_reg, drc_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_p_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_p_reg <= 1'b1;
      pins_m_reg <= 8'h00;
      pins_s_reg <= 8'h00;
    end else begin
      scl_m_reg <= link.scl;
      scl_s_reg <= scl_m_reg;
      scl_p_reg <= scl_s_reg;
      sda_m_reg <= link.sda;
      sda_s_reg <= sda_m_reg;
      sda_p_reg <= sda_s_reg;
      pins_m_reg <= {i_slave_iface_strap, i_addr_select, i_eeprom_done,
                     i_power_down_pin, i_loopback_pin};
      pins_s_reg <= pins_m_reg;
    end
  end

  wire port_en = pins_s_reg[7];
  wire [3:0] ad_s = pins_s_reg[6:3];
  wire ee_s = pins_s_reg[2];
  wire pdpin_s = pins_s_reg[1];
  wire lbpin_s = pins_s_reg[0];
  wire rise = scl_s_reg & ~scl_p_reg;
  wire fall = ~scl_s_reg & scl_p_reg;
  wire start = scl_s_reg & scl_p_reg & sda_p_reg & ~sda_s_reg;
  wire stop = scl_s_reg & scl_p_reg & ~sda_p_reg & sda_s_reg;
  wire both_high = scl_s_reg & sda_s_reg;
  wire bus_idle = stop_seen_reg ? (idle_cnt_reg >= IDLE_W'(smbsp_pkg::BUF_CYC))
                                : (idle_cnt_reg >= IDLE_W'(smbsp_pkg::HIGH_CYC));
  // own address byte, direction bit clear
  wire [7:0] own_addr = smbsp_pkg::ADDR_BASE + {3'h0, ad_s, 1'b0};
  wire addr_match = port_en & (shift_reg[7:1] == own_addr[7:1]);
  wire rx_state = (st_reg == S_ADDR) | (st_reg == S_REG) | (st_reg == S_WDATA);
  wire byte_done = (cnt_reg == smbsp_pkg::BYTE_BITS);

  // register read mux
  wire [7:0] obs_val = obs_rw_reg | ({4'h0, ad_s} << smbsp_pkg::OBS_AD_LSB)
                       | ({7'h00, ee_s} << smbsp_pkg::OBS_EE_BIT);
  wire [7:0] rd_data = (ptr_reg == smbsp_pkg::REG_OBS) ? obs_val :
                       (ptr_reg == smbsp_pkg::REG_PD) ? pd_reg :
                       (ptr_reg == smbsp_pkg::REG_LPO) ? lpo_reg :
                       (ptr_reg == smbsp_pkg::REG_CRC) ? crc_reg :
                       (ptr_reg == smbsp_pkg::REG_SRC) ? src_reg :
                       (ptr_reg == smbsp_pkg::REG_DRC) ? drc_reg : 8'h00;

  // write decode
  wire chan_ok = src_reg[smbsp_pkg::SRC_REGEN_BIT]
                 | (crc_reg == smbsp_crc8(shift_reg));
  wire wr_obs = wr_fire & (ptr_reg == smbsp_pkg::REG_OBS);
  wire wr_pd = wr_fire & (ptr_reg == smbsp_pkg::REG_PD) & chan_ok;
  wire wr_lpo = wr_fire & (ptr_reg == smbsp_pkg::REG_LPO) & chan_ok;
  wire wr_crc = wr_fire & (ptr_reg == smbsp_pkg::REG_CRC);
  wire wr_src = wr_fire & (ptr_reg == smbsp_pkg::REG_SRC);
  wire wr_drc = wr_fire & (ptr_reg == smbsp_pkg::REG_DRC);
  wire reg_reset = wr_drc & shift_reg[smbsp_pkg::DRC_REGRST_BIT];

  // serial engine next state
  always_comb begin
    st_next = st_reg;
    after_next = after_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    tx_next = tx_reg;
    oe_n_next = oe_n_reg;
    wr_fire = 1'b0;
    // idle timer clears a cycle late, so a start must win over idle
    if (!port_en || (bus_idle && !start)) begin
      st_next = S_IDLE;
      oe_n_next = 1'b1;
    end else if (start) begin
      st_next = S_ADDR;
      cnt_next = 4'h0;
      oe_n_next = 1'b1;
    end else if (stop) begin
      st_next = S_IDLE;
      oe_n_next = 1'b1;
    end else if (rise) begin
      if (rx_state) begin
        shift_next = {shift_reg[6:0], sda_s_reg};
        cnt_next = cnt_reg + 4'h1;
      end else if (st_reg == S_READ) begin
        cnt_next = cnt_reg + 4'h1;
      end
    end else if (fall) begin
      // ack and read-bit drive changes happen just after scl falls
      unique case (st_reg)
        S_ADDR: begin
          if (byte_done) begin
            if (addr_match) begin
              oe_n_next = 1'b0;
              after_next = shift_reg[0] ? S_READ : S_REG;
              st_next = S_ACK;
            end else begin
              st_next = S_IGNORE;
            end
          end
        end
        S_REG: begin
          if (byte_done) begin
            ptr_next = shift_reg;
            oe_n_next = 1'b0;
            after_next = S_WDATA;
            st_next = S_ACK;
          end
        end
        S_WDATA: begin
          if (byte_done) begin
            wr_fire = 1'b1;
            oe_n_next = 1'b0;
            after_next = S_IGNORE;
            st_next = S_ACK;
          end
        end
        S_ACK: begin
          cnt_next = 4'h0;
          st_next = after_reg;
          tx_next = rd_data;
          oe_n_next = (after_reg == S_READ) ? rd_data[7] : 1'b1;
        end
        S_READ: begin
          if (byte_done) begin
            oe_n_next = 1'b1;
            st_next = S_IGNORE;
          end else begin
            tx_next = {tx_reg[6:0], 1'b0};
            oe_n_next = tx_reg[6];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_reg <= S_IDLE;
      after_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      tx_reg <= 8'h00;
      oe_n_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      after_reg <= after_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      tx_reg <= tx_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // idle timer: counts while both lines stay high
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      idle_cnt_reg <= '0;
      stop_seen_reg <= 1'b0;
    end else begin
      if (!both_high) begin
        idle_cnt_reg <= '0;
      end else if (!bus_idle) begin
        idle_cnt_reg <= idle_cnt_reg + IDLE_W'(1);
      end
      if (stop) begin
        stop_seen_reg <= 1'b1;
      end else if (start) begin
        stop_seen_reg <= 1'b0;
      end
    end
  end

  // register file
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || reg_reset) begin
      obs_rw_reg <= smbsp_pkg::OBS_RST;
      pd_reg <= smbsp_pkg::PD_RST;
      lpo_reg <= smbsp_pkg::LPO_RST;
      crc_reg <= smbsp_pkg::CRC_RST;
      src_reg <= smbsp_pkg::SRC_RST;
      drc_reg <= smbsp_pkg::DRC_RST;
    end else begin
      if (wr_obs) obs_rw_reg <= shift_reg & smbsp_pkg::OBS_RW_MASK;
      if (wr_pd) pd_reg <= shift_reg;
      if (wr_lpo) lpo_reg <= shift_reg & smbsp_pkg::LPO_MASK;
      if (wr_crc) crc_reg <= shift_reg;
      if (wr_src) src_reg <= shift_reg;
      if (wr_drc) drc_reg <= shift_reg & smbsp_pkg::DRC_STORE_MASK;
    end
  end

  // lane controls
  wire pd_ovr = lpo_reg[smbsp_pkg::LPO_OVR_BIT];
  wire [1:0] lb_sel = lpo_reg[smbsp_pkg::LPO_LB_LSB +: 2];
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_per_lane_power_down <= 8'h00;
      o_loop_a_to_b <= 1'b0;
      o_loop_b_to_a <= 1'b0;
    end else begin
      o_per_lane_power_down <= pd_ovr ? pd_reg : {8{pdpin_s}};
      o_loop_a_to_b <= (lb_sel == smbsp_pkg::LB_A2B)
                       | ((lb_sel == smbsp_pkg::LB_PIN) & lbpin_s);
      o_loop_b_to_a <= (lb_sel == smbsp_pkg::LB_B2A)
                       | ((lb_sel == smbsp_pkg::LB_PIN) & lbpin_s);
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe_n = oe_n_reg;
endmodule : smbsp_dev

/* logic/smbsp_pkg.sv */
// Purpose: shared constants for the smbus slave port and its host
// Assumes: 20 MHz reference clock on both ends
// Notes: device register offsets are byte addresses on the serial link
package smbsp_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_NS = 50;
  // bus-free and longest clock-high times
  localparam int T_BUF_NS = 4700;
  localparam int T_HIGH_MAX_NS = 50000;
  localparam int BUF_CYC = (T_BUF_NS + CLK_NS - 1) / CLK_NS;
  localparam int HIGH_CYC = T_HIGH_MAX_NS / CLK_NS;
  localparam int IDLE_W = 11;
  // host serial clock, quarter bit per tick
  localparam int SCL_HZ = 100_000;
  localparam int QTR_CYC = CLK_HZ / (4 * SCL_HZ);
  // device address
  localparam logic [7:0] ADDR_BASE = 8'hb0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // device register offsets
  localparam logic [7:0] REG_OBS = 8'h00;
  localparam logic [7:0] REG_PD = 8'h01;
  localparam logic [7:0] REG_LPO = 8'h02;
  localparam logic [7:0] REG_CRC = 8'h05;
  localparam logic [7:0] REG_SRC = 8'h06;
  localparam logic [7:0] REG_DRC = 8'h07;
  // device reset values
  localparam logic [7:0] OBS_RST = 8'h00;
  localparam logic [7:0] PD_RST = 8'h00;
  localparam logic [7:0] LPO_RST = 8'h00;
  localparam logic [7:0] CRC_RST = 8'h00;
  localparam logic [7:0] SRC_RST = 8'h10;
  localparam logic [7:0] DRC_RST = 8'h01;
  // device field positions and masks
  localparam int OBS_AD_LSB = 3;
  localparam int OBS_EE_BIT = 2;
  localparam logic [7:0] OBS_RW_MASK = 8'h83;
  localparam logic [7:0] LPO_MASK = 8'h31;
  localparam int LPO_OVR_BIT = 0;
  localparam int LPO_LB_LSB = 4;
  localparam int SRC_REGEN_BIT = 3;
  localparam int DRC_REGRST_BIT = 6;
  localparam logic [7:0] DRC_STORE_MASK = 8'hbf;
  localparam logic [7:0] CRC_POLY = 8'h07;
  // loopback field codes
  localparam logic [1:0] LB_PIN = 2'h0;
  localparam logic [1:0] LB_A2B = 2'h1;
  localparam logic [1:0] LB_B2A = 2'h2;
  // host wishbone offsets
  localparam logic [7:0] HW_CMD = 8'h00;
  localparam logic [7:0] HW_SLV = 8'h04;
  localparam logic [7:0] HW_REG = 8'h08;
  localparam logic [7:0] HW_WDAT = 8'h0c;
  localparam logic [7:0] HW_STAT = 8'h10;
  localparam logic [7:0] HW_RDAT = 8'h14;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_RD_BIT = 1;
endpackage : smbsp_pkg

/* logic/smbsp_link_if.sv */
// Purpose: two-wire link between host and device
// Assumes: open-drain lines with pull-ups; enables active low
// Notes: a line is low when any enabled driver drives low
`timescale 1ns/1ps
interface smbsp_link_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  wire scl;
  wire sda;
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
  modport host(output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n, input scl, sda);
  modport dev(output dev_sda_o, dev_sda_oe_n, input scl, sda);
endinterface : smbsp_link_if

/* logic/smbsp_host.sv */
// Purpose: smbus host issuing single register writes and reads
// Assumes: classic wishbone slave for orders and status
// Notes: scl made here by a quarter-bit divider, no clock stretching
`timescale 1ns/1ps
module smbsp_host #(
  parameter int QTR_CYC = smbsp_pkg::QTR_CYC
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // serial link
  smbsp_link_if.host link,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack
);
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_START = 2'h1,
    H_BIT = 2'h3,
    H_STOP = 2'h2
  } smbsp_hstate_t;

  smbsp_hstate_t st_reg;
  logic [15:0] div_reg;
  logic [1:0] ph_reg, idx_reg;
  logic [3:0] bit_reg;
  logic [8:0] frame_reg, rx_reg;
  logic scl_low_reg, sda_low_reg, busy_reg, nack_reg, done_reg, rnw_reg;
  logic [6:0] slv_reg;
  logic [7:0] regad_reg, wdat_reg, rdat_reg;
  logic sda_m_reg, sda_s_reg;

  // frame for byte slot: data then released ack bit
  function automatic logic [8:0] smbsp_frame(input logic [1:0] idx, input logic rd,
                                             input logic [6:0] slv, input logic [7:0] ra,
                                             input logic [7:0] wd);
    logic [8:0] f;
    f = 9'h1ff;
    if (idx == 2'h0) f = {slv, 1'b0, 1'b1};
    else if (idx == 2'h1) f = {ra, 1'b1};
    else if (idx == 2'h2) f = rd ? {slv, 1'b1, 1'b1} : {wd, 1'b1};
    return f;
  endfunction : smbsp_frame

  wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wb_wr = wb_req & i_wb_we & i_wb_sel[0];
  wire go = wb_wr & (i_wb_adr == smbsp_pkg::HW_CMD) & i_wb_dat[smbsp_pkg::CMD_GO_BIT] & ~busy_reg;
  wire tick = (div_reg == 16'(QTR_CYC - 1));
  wire rd_byte = (idx_reg == 2'h3);
  wire last_byte = rnw_reg ? rd_byte : (idx_reg == 2'h2);
  wire nack_now = ~rd_byte & rx_reg[0];
  wire [8:0] next_frame = smbsp_frame(idx_reg + 2'h1, rnw_reg, slv_reg, regad_reg, wdat_reg);
  wire [31:0] rd_mux = (i_wb_adr == smbsp_pkg::HW_SLV) ? {25'h0, slv_reg} :
                       (i_wb_adr == smbsp_pkg::HW_REG) ? {24'h0, regad_reg} :
                       (i_wb_adr == smbsp_pkg::HW_WDAT) ? {24'h0, wdat_reg} :
                       (i_wb_adr == smbsp_pkg::HW_STAT) ? {29'h0, done_reg, nack_reg, busy_reg} :
                       (i_wb_adr == smbsp_pkg::HW_RDAT) ? {24'h0, rdat_reg} : 32'h0;

  // wishbone answers one cycle after the request
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
      slv_reg <= 7'h00;
      regad_reg <= 8'h00;
      wdat_reg <= 8'h00;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= wb_req ? rd_mux : 32'h0;
      if (wb_wr && i_wb_adr == smbsp_pkg::HW_SLV) slv_reg <= i_wb_dat[6:0];
      if (wb_wr && i_wb_adr == smbsp_pkg::HW_REG) regad_reg <= i_wb_dat[7:0];
      if (wb_wr && i_wb_adr == smbsp_pkg::HW_WDAT) wdat_reg <= i_wb_dat[7:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || go) begin
      div_reg <= 16'h0;
    end else begin
      div_reg <= tick ? 16'h0 : div_reg + 16'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end else begin
      sda_m_reg <= link.sda;
      sda_s_reg <= sda_m_reg;
    end
  end

  // bit sequencer; data bits change in quarters with scl low, start and stop move sda with scl high
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_reg <= H_IDLE;
      ph_reg <= 2'h0;
      idx_reg <= 2'h0;
      bit_reg <= 4'h0;
      frame_reg <= 9'h1ff;
      rx_reg <= 9'h000;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      busy_reg <= 1'b0;
      nack_reg <= 1'b0;
      done_reg <= 1'b0;
      rnw_reg <= 1'b0;
      rdat_reg <= 8'h00;
    end else if (go) begin
      st_reg <= H_START;
      ph_reg <= 2'h0;
      idx_reg <= 2'h0;
      busy_reg <= 1'b1;
      nack_reg <= 1'b0;
      done_reg <= 1'b0;
      rnw_reg <= i_wb_dat[smbsp_pkg::CMD_RD_BIT];
    end else if (tick && st_reg != H_IDLE) begin
      ph_reg <= ph_reg + 2'h1;
      unique case (st_reg)
        H_START: begin
          if (ph_reg == 2'h0) begin
            scl_low_reg <= 1'b1;
            sda_low_reg <= 1'b0;
          end
          if (ph_reg == 2'h1) scl_low_reg <= 1'b0;
          if (ph_reg == 2'h2) sda_low_reg <= 1'b1;
          if (ph_reg == 2'h3) begin
            scl_low_reg <= 1'b1;
            st_reg <= H_BIT;
            bit_reg <= 4'h0;
            frame_reg <= smbsp_frame(idx_reg, rnw_reg, slv_reg, regad_reg, wdat_reg);
          end
        end
        H_BIT: begin
          if (ph_reg == 2'h0) sda_low_reg <= ~frame_reg[8];
          if (ph_reg == 2'h1) scl_low_reg <= 1'b0;
          if (ph_reg == 2'h2) rx_reg <= {rx_reg[7:0], sda_s_reg};
          if (ph_reg == 2'h3) begin
            scl_low_reg <= 1'b1;
            frame_reg <= {frame_reg[7:0], 1'b1};
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'h8) begin
              bit_reg <= 4'h0;
              if (nack_now) begin
                nack_reg <= 1'b1;
                st_reg <= H_STOP;
              end else if (last_byte) begin
                if (rd_byte) rdat_reg <= rx_reg[8:1];
                st_reg <= H_STOP;
              end else if (rnw_reg && idx_reg == 2'h1) begin
                idx_reg <= 2'h2;
                st_reg <= H_START;
              end else begin
                idx_reg <= idx_reg + 2'h1;
                frame_reg <= next_frame;
              end
            end
          end
        end
        H_STOP: begin
          if (ph_reg == 2'h0) sda_low_reg <= 1'b1;
          if (ph_reg == 2'h1) scl_low_reg <= 1'b0;
          if (ph_reg == 2'h2) sda_low_reg <= 1'b0;
          if (ph_reg == 2'h3) begin
            st_reg <= H_IDLE;
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe_n = ~scl_low_reg;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe_n = ~sda_low_reg;
endmodule : smbsp_host

/* verification/smbsp_link_sva.sv */
// Purpose: wire checks on the smbus link between host and device
// Assumes: link lines move only on the 20 MHz reference clock
// Notes: bit count restarts at every start condition
`timescale 1ns/1ps
module smbsp_link_sva (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // link lines
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe_n
);
  logic scl_reg;
  logic sda_reg;
  logic rd_reg;
  logic ack_reg;
  logic [5:0] cnt_reg;
  wire hi = scl & scl_reg;
  wire st = hi & sda_reg & ~sda;
  wire sp = hi & ~sda_reg & sda;
  wire rise = scl & ~scl_reg;
  wire ack_slot = (cnt_reg % 6'h9) == 6'h0;
  always_ff @(posedge i_ref_clk) begin
    scl_reg <= scl;
    sda_reg <= sda;
  end
  // scl rises since the last start
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || st) begin
      cnt_reg <= 6'h0;
    end else if (rise) begin
      cnt_reg <= cnt_reg + 6'h1;
    end
  end
  // direction bit of the address byte
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rd_reg <= 1'b0;
    end else if (rise && cnt_reg == 6'h7) begin
      rd_reg <= sda;
    end
  end
  // write-direction address acked in this message
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || sp) begin
      ack_reg <= 1'b0;
    end else if (hi && cnt_reg == 6'h9 && !rd_reg && !dev_sda_oe_n) begin
      ack_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  a_addr_quiet: assert property (hi && cnt_reg > 6'h0 && cnt_reg < 6'h9
    |-> dev_sda_oe_n)
    else $error("device drove sda during address bits");
  a_wr_data_quiet: assert property (hi && !rd_reg && !ack_slot |-> dev_sda_oe_n)
    else $error("device drove sda outside an ack slot");
  a_reg_ack_low: assert property (hi && !rd_reg && ack_reg
    && (cnt_reg == 6'h12 || cnt_reg == 6'h1b) |-> !dev_sda_oe_n)
    else $error("device missed ack of register or data byte");
  a_read_ack_low: assert property (hi && rd_reg && ack_reg && cnt_reg == 6'h9
    |-> !dev_sda_oe_n)
    else $error("device missed ack of read address");
  a_nack_released: assert property (hi && rd_reg && cnt_reg == 6'h12
    |-> dev_sda_oe_n)
    else $error("device held sda in host nack slot");
  a_stable_high: assert property (hi |-> $stable(dev_sda_oe_n))
    else $error("device sda moved while scl high");
  a_change_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device sda changed with scl high");
  a_drive_bounded: assert property ($fell(dev_sda_oe_n) |-> ##[1:800] dev_sda_oe_n)
    else $error("device held sda too long");
  a_stop_quiet: assert property (sp |-> dev_sda_oe_n [*8])
    else $error("device drove sda after stop");
  c_write_done: cover property (ack_reg && sp);
  c_read_nack: cover property (hi && rd_reg && cnt_reg == 6'h12);
  c_addr_nack: cover property (hi && cnt_reg == 6'h9 && dev_sda_oe_n);
endmodule : smbsp_link_sva

/* verification/smbus_slave_config_port_tb.sv */
// Purpose: host and device joined over the link, driven over wishbone
// Assumes: host scl divider shortened to 20 cycles a quarter bit
// Notes: lane outputs and register reads checked after some transfers; setup writes go unchecked
`timescale 1ns/1ps
module smbus_slave_config_port_tb;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat_w;
  logic ack;
  logic strap = 1'b1;
  logic pd_pin = 1'b1;
  logic lb_pin = 1'b1;
  logic ee = 1'b1;
  logic [3:0] sel_ad = 4'h0;
  logic [7:0] lanes;
  logic a2b;
  logic b2a;
  logic [31:0] d;
  logic [7:0] rb;
  logic nk;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  smbsp_link_if link();
  smbsp_host #(.QTR_CYC(20)) i_smbsp_host (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .link(link),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
    .i_wb_dat(wdat), .o_wb_dat(rdat_w), .o_wb_ack(ack));
  smbsp_dev i_smbsp_dev (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .link(link),
    .i_slave_iface_strap(strap), .i_addr_select(sel_ad), .i_power_down_pin(pd_pin),
    .i_loopback_pin(lb_pin), .i_eeprom_done(ee), .o_per_lane_power_down(lanes),
    .o_loop_a_to_b(a2b), .o_loop_b_to_a(b2a));
  smbsp_link_sva i_smbsp_link_sva (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .scl(link.scl),
    .sda(link.sda), .dev_sda_oe_n(link.dev_sda_oe_n));
  initial begin
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  task automatic final_report;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      errors = errors + 1;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge i_ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    do @(posedge i_ref_clk); while (ack !== 1'b1);
    d = rdat_w;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // one register transfer on the link, then bus idle time
  task automatic smb(input logic r, input logic [6:0] s, input logic [7:0] ra,
    input logic [7:0] wd);
    wb(1'b1, smbsp_pkg::HW_SLV, {25'h0, s});
    wb(1'b1, smbsp_pkg::HW_REG, {24'h0, ra});
    wb(1'b1, smbsp_pkg::HW_WDAT, {24'h0, wd});
    wb(1'b1, smbsp_pkg::HW_CMD, {30'h0, r, 1'b1});
    d = 32'h1;
    while ((d[2] | d[1]) !== 1'b1 || d[0] !== 1'b0) wb(1'b0, smbsp_pkg::HW_STAT, 32'h0);
    nk = d[1];
    wb(1'b0, smbsp_pkg::HW_RDAT, 32'h0);
    rb = d[7:0];
    repeat (120) @(posedge i_ref_clk);
  endtask : smb
  function automatic logic [7:0] crc8(input logic [7:0] v);
    logic [7:0] c;
    c = v;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ smbsp_pkg::CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (1100) @(posedge i_ref_clk);
    wb(1'b0, 8'h18, 32'h0);
    chk(d[15:0], 16'h0);
    chk({lanes, 6'h0, a2b, b2a}, 16'hff03);
    smb(1'b1, 7'h58, smbsp_pkg::REG_OBS, 8'h0);
    chk({7'h0, nk, rb}, 16'h0004);
    smb(1'b0, 7'h58, smbsp_pkg::REG_PD, 8'h33);
    smb(1'b1, 7'h58, smbsp_pkg::REG_PD, 8'h0);
    chk({8'h0, rb}, 16'h0);
    smb(1'b0, 7'h58, smbsp_pkg::REG_CRC, crc8(8'h33));
    smb(1'b0, 7'h58, smbsp_pkg::REG_PD, 8'h33);
    smb(1'b1, 7'h58, smbsp_pkg::REG_PD, 8'h0);
    chk({7'h0, nk, rb}, 16'h0033);
    smb(1'b0, 7'h58, smbsp_pkg::REG_SRC, 8'h18);
    for (int c = 0; c < 4; c++) begin
      smb(1'b0, 7'h58, smbsp_pkg::REG_LPO, {2'h0, c[1:0], 4'h1});
      chk({lanes, 6'h0, a2b, b2a}, {8'h33, 6'h0, c < 2, !c[0]});
    end
    sel_ad <= 4'ha;
    ee <= 1'b0;
    repeat (10) @(posedge i_ref_clk);
    smb(1'b1, 7'h62, smbsp_pkg::REG_OBS, 8'h0);
    chk({7'h0, nk, rb}, 16'h0050);
    smb(1'b0, 7'h58, smbsp_pkg::REG_PD, 8'h0f);
    chk({7'h0, nk, lanes}, 16'h0133);
    strap <= 1'b0;
    smb(1'b1, 7'h62, smbsp_pkg::REG_OBS, 8'h0);
    chk({15'h0, nk}, 16'h1);
    strap <= 1'b1;
    repeat (1100) @(posedge i_ref_clk);
    smb(1'b0, 7'h62, smbsp_pkg::REG_DRC, 8'h40);
    smb(1'b1, 7'h62, smbsp_pkg::REG_PD, 8'h0);
    chk({rb, lanes}, 16'h00ff);
    smb(1'b1, 7'h62, smbsp_pkg::REG_DRC, 8'h0);
    chk({8'h0, rb}, 16'h0001);
    final_report();
  end
endmodule : smbus_slave_config_port_tb
